// ---- logic/ech_pkg.sv ----
package ech_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0]  IDX_UPPER   = 8'h0c;
    localparam logic [7:0]  IDX_LOWER   = 8'h0d;
    localparam logic [7:0]  IDX_EDGE    = 8'h0e;
    localparam logic [7:0]  IDX_LEVEL   = 8'h0f;
    localparam logic [7:0]  IDX_CHEN    = 8'h1b;
    localparam logic [7:0]  IDX_OOR     = 8'h1c;
    localparam logic [7:0]  IDX_LIVE    = 8'h1d;
    // reset values
    localparam logic [23:0] RST_UPPER   = 24'h00ffff;
    localparam logic [23:0] RST_LOWER   = 24'h000000;
    localparam logic [23:0] RST_EDGE    = 24'h000001;
    localparam logic [23:0] RST_LEVEL   = 24'h000001;
    // writable bits of the margin registers; bits 23:20 read zero
    localparam logic [23:0] MASK_MARGIN = 24'h0fffff;
    localparam logic [23:0] MASK_PACE   = 24'hffffff;
    // field positions
    localparam int          MARGIN_LSB  = 16;
    localparam int          MARGIN_W    = 4;
    localparam int          DETACH_W    = 16;
    localparam int          PACER_W     = 8;
    localparam int          STEP_SHIFT  = 6;
    localparam int          LIVE_DLO    = 8;
    localparam int          LIVE_EDGE   = 16;
    localparam int          LIVE_LVL    = 20;
    // the deepest margin code moves the high limit this far from full scale and the low limit this far from zero
    localparam logic [23:0] LIMIT_SPAN  = 24'h0003c0;
    // bus
    localparam int          ADDR_W      = 12;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } ech_axi_req_s;

    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } ech_axi_rsp_s;
endpackage

// ---- logic/ech_chan_check.sv ----
module ech_chan_check #(
    parameter int DW = 24
) (
    // conversion and ac detection inputs
    input  wire logic [DW-1:0]                conv_data,
    input  wire logic [ech_pkg::DETACH_W-1:0] ac_level,
    // programmed limits
    input  wire logic [ech_pkg::MARGIN_W-1:0] high_margin,
    input  wire logic [ech_pkg::MARGIN_W-1:0] low_margin,
    input  wire logic [ech_pkg::DETACH_W-1:0] upper_level,
    input  wire logic [ech_pkg::DETACH_W-1:0] lower_level,
    // comparison results
    output logic                              over,
    output logic                              under,
    output logic                              detach_hi,
    output logic                              detach_lo
);
    import ech_pkg::*;

    localparam int PAD = DW - MARGIN_W - STEP_SHIFT;

    if (PAD < 1) begin : g_chk
        $error("ech_chan_check: DW too narrow for the margin step");
    end

    logic [DW-1:0] high_limit;
    logic [DW-1:0] low_limit;

    // margin times 64 taken off full scale, or added to zero
    assign high_limit = {DW{1'b1}} - {{PAD{1'b0}}, high_margin, {STEP_SHIFT{1'b0}}};
    assign low_limit  = {{PAD{1'b0}}, low_margin, {STEP_SHIFT{1'b0}}};
    assign over       = conv_data > high_limit;
    assign under      = conv_data < low_limit;
    assign detach_hi  = ac_level >= upper_level;
    assign detach_lo  = ac_level <= lower_level;
endmodule

// ---- logic/ech_pace_check.sv ----
module ech_pace_check (
    // pace front-end measurements
    input  wire logic [15:0]                 slope,
    input  wire logic [15:0]                 level,
    // programmed thresholds
    input  wire logic [ech_pkg::PACER_W-1:0] slope_limit,
    input  wire logic [ech_pkg::PACER_W-1:0] level_limit,
    input  wire logic [ech_pkg::PACER_W-1:0] amplitude_limit,
    // comparison results
    output logic                             edge_hit,
    output logic                             level_hit
);
    import ech_pkg::*;

    logic [PACER_W-1:0] eff_slope;
    logic signed [15:0] lvl_thr;

    // zero falls back to half the amplitude threshold
    assign eff_slope = (slope_limit == '0) ? {1'b0, amplitude_limit[PACER_W-1:1]}
                                            : slope_limit;
    assign edge_hit  = slope >= {8'h00, eff_slope};
    // signed steps: a negative limit trips on the way down
    assign lvl_thr   = {{8{level_limit[PACER_W-1]}}, level_limit};
    assign level_hit = level_limit[PACER_W-1] ? ($signed(level) <= lvl_thr)
                                              : ($signed(level) >= lvl_thr);
endmodule

// ---- logic/ech_threshold_bank.sv ----
// Summary of operation
// - A conversion above full scale minus the high margin times 64 is out of range.
// - High margin zero leaves the limit at full scale; code 1111 puts it 960 below.
// - A conversion below zero plus the low margin times 64 is out of range.
// - Low margin zero leaves the limit at zero; code 1111 puts it 960 above.
// - Ac detach is reported when the level is at or above the upper level field.
// - Ac detach is reported when the level is at or below the lower level field.
// - Each pace channel has its own 8-bit slope limit; zero means half the amplitude limit.
// - Each pace channel level limit is a signed twos-complement step count.
// - The upper level register sits at index 0x0c and resets to 0x00ffff.
//
// The implementer's own choice: register access over AXI4-Lite.
module ech_threshold_bank #(
    parameter int NCH = 5,
    parameter int NPACE = 3,
    parameter int DW = 24
) (
    // clock and reset
    input  wire logic                               aclk,
    input  wire logic                               aresetn,
    // register bus
    input  wire ech_pkg::ech_axi_req_s              axi_req,
    output ech_pkg::ech_axi_rsp_s                   axi_rsp,
    // conversions
    input  wire logic                               conv_valid,
    input  wire logic [NCH*DW-1:0]                  conv_data,
    // ac detach measurement
    input  wire logic                               ac_valid,
    input  wire logic [NCH*ech_pkg::DETACH_W-1:0]   ac_level,
    // pace measurement
    input  wire logic                               pace_valid,
    input  wire logic [NPACE*16-1:0]                pace_slope,
    input  wire logic [NPACE*16-1:0]                pace_level,
    input  wire logic [ech_pkg::PACER_W-1:0]        pacer_amplitude_limit,
    // results
    output logic [NCH-1:0]                          oor_err,
    output logic [NCH-1:0]                          detach_hi,
    output logic [NCH-1:0]                          detach_lo,
    output logic [NPACE-1:0]                        pace_edge_hit,
    output logic [NPACE-1:0]                        pace_level_hit
);
    import ech_pkg::*;

    if (NCH < 1 || NCH > 8 || NPACE < 1 || NPACE > 3 || DW < 11) begin : g_chk
        $error("ech_threshold_bank: unsupported channel count or width");
    end

    typedef struct packed {
        logic              aw_ok;
        logic              w_ok;
        logic [7:0]        widx;
        logic [23:0]       wdata;
        logic [2:0]        wstrb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [31:0]       rdata;
        logic [23:0]       upper;
        logic [23:0]       lower;
        logic [23:0]       slope;
        logic [23:0]       level;
        logic [NCH-1:0]    chen;
        logic [NCH-1:0]    oor_sticky;
        logic [NCH-1:0]    oor;
        logic [NCH-1:0]    dhi;
        logic [NCH-1:0]    dlo;
        logic [NPACE-1:0]  edge_hit;
        logic [NPACE-1:0]  lvl_hit;
    } ech_state_s;

    ech_state_s st;
    ech_state_s next_st;

    logic [NCH-1:0]   over;
    logic [NCH-1:0]   under;
    logic [NCH-1:0]   dhi_now;
    logic [NCH-1:0]   dlo_now;
    logic [NPACE-1:0] edge_now;
    logic [NPACE-1:0] lvl_now;

    for (genvar c = 0; c < NCH; c++) begin : g_chan
        ech_chan_check #(
            .DW(DW)
        ) u_chk (
            .conv_data   (conv_data[c*DW +: DW]),
            .ac_level    (ac_level[c*DETACH_W +: DETACH_W]),
            .high_margin (st.upper[MARGIN_LSB +: MARGIN_W]),
            .low_margin  (st.lower[MARGIN_LSB +: MARGIN_W]),
            .upper_level (st.upper[DETACH_W-1:0]),
            .lower_level (st.lower[DETACH_W-1:0]),
            .over        (over[c]),
            .under       (under[c]),
            .detach_hi   (dhi_now[c]),
            .detach_lo   (dlo_now[c])
        );
    end

    for (genvar p = 0; p < NPACE; p++) begin : g_pace
        ech_pace_check u_pace (
            .slope           (pace_slope[p*16 +: 16]),
            .level           (pace_level[p*16 +: 16]),
            .slope_limit     (st.slope[p*PACER_W +: PACER_W]),
            .level_limit     (st.level[p*PACER_W +: PACER_W]),
            .amplitude_limit (pacer_amplitude_limit),
            .edge_hit        (edge_now[p]),
            .level_hit       (lvl_now[p])
        );
    end

    function automatic logic [23:0] merge(input logic [23:0] old, input logic [23:0] val,
                                          input logic [2:0] strb, input logic [23:0] mask);
        logic [23:0] res;
        res = old;
        for (int b = 0; b < 3; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = val[b*8 +: 8];
            end
        end
        return res & mask;
    endfunction

    assign axi_rsp.awready = !st.aw_ok;
    assign axi_rsp.wready  = !st.w_ok;
    assign axi_rsp.bvalid  = st.bvalid;
    assign axi_rsp.bresp   = st.bresp;
    assign axi_rsp.arready = !st.rvalid;
    assign axi_rsp.rvalid  = st.rvalid;
    assign axi_rsp.rdata   = st.rdata;
    assign axi_rsp.rresp   = st.rresp;

    assign oor_err        = st.oor;
    assign detach_hi      = st.dhi;
    assign detach_lo      = st.dlo;
    assign pace_edge_hit  = st.edge_hit;
    assign pace_level_hit = st.lvl_hit;

    always_comb begin
        logic [NCH-1:0] oor_set;
        logic [NCH-1:0] oor_clr;
        logic [31:0]    live;
        logic [7:0]     ridx;
        next_st = st;
        oor_set = '0;
        oor_clr = '0;
        live    = '0;
        ridx    = axi_req.araddr[9:2];
        live[NCH-1:0]              = st.dhi;
        live[LIVE_DLO +: NCH]      = st.dlo;
        live[LIVE_EDGE +: NPACE]   = st.edge_hit;
        live[LIVE_LVL +: NPACE]    = st.lvl_hit;

        // address and data may come in either order
        if (axi_req.awvalid && !st.aw_ok) begin
            next_st.aw_ok = 1'b1;
            next_st.widx  = axi_req.awaddr[9:2];
        end
        if (axi_req.wvalid && !st.w_ok) begin
            next_st.w_ok  = 1'b1;
            next_st.wdata = axi_req.wdata[23:0];
            next_st.wstrb = axi_req.wstrb[2:0];
        end
        if (st.aw_ok && st.w_ok && !st.bvalid) begin
            next_st.aw_ok  = 1'b0;
            next_st.w_ok   = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = RESP_OKAY;
            unique case (st.widx)
                IDX_UPPER: begin
                    next_st.upper = merge(st.upper, st.wdata, st.wstrb, MASK_MARGIN);
                end
                IDX_LOWER: begin
                    next_st.lower = merge(st.lower, st.wdata, st.wstrb, MASK_MARGIN);
                end
                IDX_EDGE: begin
                    next_st.slope = merge(st.slope, st.wdata, st.wstrb, MASK_PACE);
                end
                IDX_LEVEL: begin
                    next_st.level = merge(st.level, st.wdata, st.wstrb, MASK_PACE);
                end
                IDX_CHEN: begin
                    if (st.wstrb[0]) begin
                        next_st.chen = st.wdata[NCH-1:0];
                    end
                end
                IDX_OOR: begin
                    if (st.wstrb[0]) begin
                        oor_clr = st.wdata[NCH-1:0];
                    end
                end
                IDX_LIVE: begin
                    next_st.bresp = RESP_OKAY;
                end
                default: begin
                    next_st.bresp = RESP_SLVERR;
                end
            endcase
        end
        if (st.bvalid && axi_req.bready) begin
            next_st.bvalid = 1'b0;
        end

        if (axi_req.arvalid && !st.rvalid) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = RESP_OKAY;
            next_st.rdata  = '0;
            unique case (ridx)
                IDX_UPPER: next_st.rdata[23:0] = st.upper;
                IDX_LOWER: next_st.rdata[23:0] = st.lower;
                IDX_EDGE:  next_st.rdata[23:0] = st.slope;
                IDX_LEVEL: next_st.rdata[23:0] = st.level;
                IDX_CHEN:  next_st.rdata[NCH-1:0] = st.chen;
                IDX_OOR:   next_st.rdata[NCH-1:0] = st.oor_sticky;
                IDX_LIVE:  next_st.rdata = live;
                default:   next_st.rresp = RESP_SLVERR;
            endcase
        end else if (st.rvalid && axi_req.rready) begin
            next_st.rvalid = 1'b0;
        end

        // each conversion refreshes the per-channel error
        if (conv_valid) begin
            next_st.oor = (over | under) & st.chen;
            oor_set     = next_st.oor;
        end
        if (ac_valid) begin
            next_st.dhi = dhi_now & st.chen;
            next_st.dlo = dlo_now & st.chen;
        end
        if (pace_valid) begin
            next_st.edge_hit = edge_now;
            next_st.lvl_hit  = lvl_now;
        end
        // a new error wins over a clear in the same cycle
        next_st.oor_sticky = (st.oor_sticky & ~oor_clr) | oor_set;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st       <= '0;
            st.upper <= RST_UPPER;
            st.lower <= RST_LOWER;
            st.slope <= RST_EDGE;
            st.level <= RST_LEVEL;
            st.chen  <= '1;
        end else begin
            st <= next_st;
        end
    end

    // checks on channel 0 and pace channel 0
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    logic [DW-1:0] full0;
    logic [DW-1:0] hi_lim0;
    logic [DW-1:0] lo_lim0;
    logic [DW-1:0] data0;
    logic [15:0]   ac0;
    logic [15:0]   slope0;
    logic [7:0]    slope_thr0;
    logic signed [15:0] lvl0;
    logic signed [7:0]  lvl_thr0;

    assign full0      = {DW{1'b1}};
    assign hi_lim0    = full0 - DW'(st.upper[19:16]) * DW'(64);
    assign lo_lim0    = DW'(st.lower[19:16]) * DW'(64);
    assign data0      = conv_data[DW-1:0];
    assign ac0        = ac_level[15:0];
    assign slope0     = pace_slope[15:0];
    assign slope_thr0 = st.slope[7:0];
    assign lvl0       = $signed(pace_level[15:0]);
    assign lvl_thr0   = $signed(st.level[7:0]);

    AST_OVER_FLAG: assert property (
        conv_valid && st.chen[0] && data0 > hi_lim0 |=> oor_err[0] && st.oor_sticky[0])
        else $error("overrange conversion not flagged");
    AST_OVER_SPAN: assert property (
        conv_valid && st.chen[0] && st.upper[19:16] == 4'hf && st.lower[19:16] == 4'h0
        && data0 == full0 - DW'(LIMIT_SPAN) |=> !oor_err[0])
        else $error("overrange limit not at full scale minus 960");
    AST_UNDER_FLAG: assert property (
        conv_valid && st.chen[0] && data0 < lo_lim0 |=> oor_err[0])
        else $error("underrange conversion not flagged");
    AST_UNDER_SPAN: assert property (
        conv_valid && st.chen[0] && st.lower[19:16] == 4'hf && st.upper[19:16] == 4'h0
        && data0 == DW'(LIMIT_SPAN) - DW'(1) |=> oor_err[0] && st.oor_sticky[0])
        else $error("underrange limit not at 960 above zero");
    AST_DETACH_HI: assert property (
        ac_valid && st.chen[0] |=> detach_hi[0] == ($past(ac0) >= $past(st.upper[15:0])))
        else $error("upper detach compare wrong");
    AST_DETACH_LO: assert property (
        ac_valid && st.chen[0] |=> detach_lo[0] == ($past(ac0) <= $past(st.lower[15:0])))
        else $error("lower detach compare wrong");
    AST_PACE_SLOPE: assert property (
        pace_valid && slope_thr0 != 8'h00
        |=> pace_edge_hit[0] == ($past(slope0) >= {8'h00, $past(slope_thr0)}))
        else $error("pace slope limit not honoured");
    AST_PACE_LEVEL: assert property (
        pace_valid && lvl_thr0 < 0 |=> pace_level_hit[0] == ($past(lvl0) <= $past(lvl_thr0)))
        else $error("negative pace level limit not signed");
    AST_UPPER_RESET: assert property (
        $rose(aresetn) |-> st.upper == RST_UPPER && axi_rsp.rvalid == 1'b0)
        else $error("upper level register reset value wrong");
    AST_STICKY_KEEP: assert property (
        oor_err[0] && $rose(oor_err[0]) && !(st.aw_ok && st.w_ok && !st.bvalid
        && st.widx == IDX_OOR) |-> st.oor_sticky[0] [*2])
        else $error("out of range error not held in status");

    // the zero margin codes switch their check off
    AST_OVER_NONE: assert property (
        conv_valid && st.chen[0] && st.upper[19:16] == 4'h0 && data0 >= lo_lim0
        |=> !oor_err[0])
        else $error("overrange flagged with zero high margin");
    AST_UNDER_NONE: assert property (
        conv_valid && st.chen[0] && st.lower[19:16] == 4'h0 && data0 <= hi_lim0
        |=> !oor_err[0])
        else $error("underrange flagged with zero low margin");

    // disabled channels stay quiet and results hold between strobes
    AST_OOR_MASK: assert property (
        conv_valid |=> (oor_err & ~$past(st.chen)) == '0)
        else $error("out of range error on a disabled channel");
    AST_OOR_HOLD: assert property (
        !conv_valid |=> $stable(oor_err))
        else $error("out of range error changed without a conversion");
    AST_DETACH_MASK: assert property (
        ac_valid |=> ((detach_hi | detach_lo) & ~$past(st.chen)) == '0)
        else $error("detach reported on a disabled channel");

    // upper level register: reserved bits, write, read back, answer
    AST_UPPER_RSVD: assert property (
        st.upper[23:20] == 4'h0)
        else $error("reserved bits of the upper level register set");
    AST_UPPER_WRITE: assert property (
        st.aw_ok && st.w_ok && !st.bvalid && st.widx == IDX_UPPER && st.wstrb == 3'h7
        |=> st.upper == ($past(st.wdata) & MASK_MARGIN))
        else $error("upper level register write lost");
    AST_UPPER_READ: assert property (
        axi_req.arvalid && axi_rsp.arready && axi_req.araddr[9:2] == IDX_UPPER
        |=> axi_rsp.rvalid && axi_rsp.rdata == {8'h00, $past(st.upper)})
        else $error("upper level register read back wrong");
    AST_WRITE_ANSWER: assert property (
        st.aw_ok && st.w_ok && !st.bvalid |=> axi_rsp.bvalid)
        else $error("write not answered");
endmodule

// ---- testbench/tb_ech_threshold_bank.sv ----
module tb_ech_threshold_bank;
    timeunit 1ns;
    timeprecision 100ps;
    import ech_pkg::*;

    localparam int NCH   = 5;
    localparam int NPACE = 3;
    localparam int DW    = 24;

    logic                      aclk;
    logic                      aresetn;
    ech_axi_req_s              axi_req;
    ech_axi_rsp_s              axi_rsp;
    logic                      conv_valid;
    logic [NCH*DW-1:0]         conv_data;
    logic                      ac_valid;
    logic [NCH*DETACH_W-1:0]   ac_level;
    logic                      pace_valid;
    logic [NPACE*16-1:0]       pace_slope;
    logic [NPACE*16-1:0]       pace_level;
    logic [PACER_W-1:0]        pacer_amplitude_limit;
    logic [NCH-1:0]            oor_err;
    logic [NCH-1:0]            detach_hi;
    logic [NCH-1:0]            detach_lo;
    logic [NPACE-1:0]          pace_edge_hit;
    logic [NPACE-1:0]          pace_level_hit;
    int                        mismatches;
    int                        checked;

    ech_threshold_bank #(.NCH(NCH), .NPACE(NPACE), .DW(DW)) u_dut (
        .aclk                  (aclk),
        .aresetn               (aresetn),
        .axi_req               (axi_req),
        .axi_rsp               (axi_rsp),
        .conv_valid            (conv_valid),
        .conv_data             (conv_data),
        .ac_valid              (ac_valid),
        .ac_level              (ac_level),
        .pace_valid            (pace_valid),
        .pace_slope            (pace_slope),
        .pace_level            (pace_level),
        .pacer_amplitude_limit (pacer_amplitude_limit),
        .oor_err               (oor_err),
        .detach_hi             (detach_hi),
        .detach_lo             (detach_lo),
        .pace_edge_hit         (pace_edge_hit),
        .pace_level_hit        (pace_level_hit)
    );

    always #5 aclk = ~aclk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // every handshake is judged at the rising edge, on the values that stand before it
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic b_t;
        int   n;
        b_t = 1'b0;
        n = 0;
        r = 2'h3;
        axi_req.awaddr  <= a;
        axi_req.wdata   <= d;
        axi_req.wstrb   <= 4'hf;
        axi_req.awvalid <= 1'b1;
        axi_req.wvalid  <= 1'b1;
        while (!b_t && n < 50) begin
            @(posedge aclk);
            if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
            if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
            b_t = axi_rsp.bvalid;
            r   = axi_rsp.bresp;
            n++;
        end
        if (!b_t) check(32'h0, 32'h1);
    endtask

    task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic r_t;
        int   n;
        r_t = 1'b0;
        n = 0;
        axi_req.araddr  <= a;
        axi_req.arvalid <= 1'b1;
        while (!r_t && n < 50) begin
            @(posedge aclk);
            if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
            r_t = axi_rsp.rvalid;
            d   = axi_rsp.rdata;
            r   = axi_rsp.rresp;
            n++;
        end
        if (!r_t) check(32'h0, 32'h1);
    endtask

    task automatic read_check(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        axi_read(a, d, r);
        check(d, exp);
        check(32'(r), 32'(er));
    endtask

    task automatic pulse_conv(input logic [NCH*DW-1:0] v);
        conv_data  <= v;
        conv_valid <= 1'b1;
        @(posedge aclk);
        conv_valid <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic test_reset_and_map();
        logic [1:0] r;
        read_check(12'h030, 32'h0000ffff, RESP_OKAY);
        read_check(12'h034, 32'h00000000, RESP_OKAY);
        read_check(12'h038, 32'h00000001, RESP_OKAY);
        read_check(12'h03c, 32'h00000001, RESP_OKAY);
        check(32'(oor_err), 32'h0);
        // unmapped index answers with an error and reads zero
        read_check(12'h040, 32'h0, RESP_SLVERR);
        axi_write(12'h040, 32'h00123456, r);
        check(32'(r), 32'(RESP_SLVERR));
        // reserved bits of a margin register read zero
        axi_write(12'h034, 32'hffffffff, r);
        read_check(12'h034, 32'h000fffff, RESP_OKAY);
    endtask

    task automatic margin_case(input logic [3:0] hm, input logic [3:0] lm);
        logic [23:0]       hi_lim;
        logic [23:0]       lo_lim;
        logic [NCH*DW-1:0] v;
        logic [NCH-1:0]    e;
        logic [1:0]        r;
        hi_lim = 24'hffffff - {14'h0, hm, 6'h0};
        lo_lim = {14'h0, lm, 6'h0};
        axi_write(12'h030, {12'h0, hm, 16'hffff}, r);
        axi_write(12'h034, {12'h0, lm, 16'h0000}, r);
        // the second vector puts the value just under the low limit on channel 0
        for (int k = 0; k < 2; k++) begin
            v = (k == 0) ? {24'h800000, lo_lim - 24'h1, lo_lim, hi_lim + 24'h1, hi_lim}
                         : {hi_lim, hi_lim + 24'h1, lo_lim, 24'h800000, lo_lim - 24'h1};
            for (int c = 0; c < NCH; c++)
                e[c] = (v[c*DW+:DW] > hi_lim) || (v[c*DW+:DW] < lo_lim);
            pulse_conv(v);
            check(32'(oor_err), 32'(e));
        end
    endtask

    task automatic test_enable_sticky();
        logic [1:0] r;
        axi_write(12'h030, 32'h0001ffff, r);
        axi_write(12'h034, 32'h00000000, r);
        axi_write(12'h06c, 32'h0000001b, r);
        axi_write(12'h070, 32'h0000001f, r);
        pulse_conv({NCH{24'hffffff}});
        check(32'(oor_err), 32'h1b);
        read_check(12'h06c, 32'h0000001b, RESP_OKAY);
        read_check(12'h070, 32'h0000001b, RESP_OKAY);
        axi_write(12'h06c, 32'h0000001f, r);
        axi_write(12'h030, 32'h0000ffff, r);
    endtask

    task automatic test_detach();
        logic [1:0] r;
        axi_write(12'h030, 32'h00001234, r);
        axi_write(12'h034, 32'h00000100, r);
        ac_level <= {16'hffff, 16'h0101, 16'h0100, 16'h1233, 16'h1234};
        ac_valid <= 1'b1;
        @(posedge aclk);
        ac_valid <= 1'b0;
        @(posedge aclk);
        check(32'(detach_hi), 32'h11);
        check(32'(detach_lo), 32'h04);
    endtask

    task automatic pace_pulse(input logic [47:0] s, input logic [47:0] l);
        pace_slope <= s;
        pace_level <= l;
        pace_valid <= 1'b1;
        @(posedge aclk);
        pace_valid <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic test_pace();
        logic [1:0] r;
        // channel 2 slope limit zero falls back to half the amplitude limit
        axi_write(12'h038, 32'h00002010, r);
        axi_write(12'h03c, 32'h000100ff, r);
        pace_pulse({16'h0020, 16'h001f, 16'h0010}, {16'h0000, 16'h0000, 16'hffff});
        check(32'(pace_edge_hit), 32'h5);
        check(32'(pace_level_hit), 32'h3);
        pace_pulse({16'h001f, 16'h0020, 16'h000f}, {16'h0001, 16'hffff, 16'h0000});
        check(32'(pace_edge_hit), 32'h2);
        check(32'(pace_level_hit), 32'h4);
        read_check(12'h074, 32'h00420411, RESP_OKAY);
    endtask

    initial begin
        automatic logic [3:0] codes[3] = '{4'h0, 4'h1, 4'hf};
        aclk = 1'b0;
        aresetn = 1'b0;
        axi_req = '0;
        axi_req.bready = 1'b1;
        axi_req.rready = 1'b1;
        conv_valid = 1'b0;
        conv_data = '0;
        ac_valid = 1'b0;
        ac_level = '0;
        pace_valid = 1'b0;
        pace_slope = '0;
        pace_level = '0;
        pacer_amplitude_limit = 8'h40;
        mismatches = 0;
        checked = 0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        test_reset_and_map();
        foreach (codes[i]) margin_case(codes[i], 4'h0);
        foreach (codes[i]) margin_case(4'h0, codes[i]);
        margin_case(4'hf, 4'hf);
        test_enable_sticky();
        test_detach();
        test_pace();
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        print_verdict();
    end
endmodule
